/* File: core/latch_write_host.sv */
/*
  host end: takes latch write and precharge requests, makes the serial clock by
  dividing sys_clk_in, and drives select, latch strobe and data on the link.
  assumes the device end samples data on the rising serial clock edge.
*/
`timescale 1ns/1ps
// Contract
// - each latch has a unique 6-bit address
// - byte is data, 6-bit address, ignored bit
// - last clock pulse writes the latch
// - writing uses serial clock and power-on reset only
// - serial clock period longer than 10 us
// - over 30 ns setup before first bit
// - commands only with select and strobe low
// - several bytes allowed in one frame
// - release strobe before a following read
// - strobe before select; data released before end
// - drive bit, raise and lower clock, eight times
// - precharge is 0xFF, sent with data undriven
// - precharge waits 1 us strobe before select
// - data changes after fall, sampled on rise
// - all lines high is idle; start from idle
// - precharge only swaps next read order
module latch_write_host
  import latch_port_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 cmd_valid_in,
  input  wire logic                 cmd_value_in,
  input  wire logic [ADDR_W-1:0]    cmd_addr_in,
  input  wire logic                 cmd_precharge_in,
  input  wire logic                 cmd_last_in,
  output logic                      cmd_ready_out,
  output logic                      busy_out,
  latch_link_if.host                link
);

  host_state_t              state_r;
  host_state_t              state_nxt;
  logic [TIMER_W-1:0]       timer_r;
  logic [TIMER_W-1:0]       timer_nxt;
  logic [CMD_BITS-1:0]      byte_r;
  logic [CMD_BITS-1:0]      byte_nxt;
  logic [CNT_W-1:0]         bit_r;
  logic [CNT_W-1:0]         bit_nxt;
  logic                     pre_r;
  logic                     pre_nxt;
  logic                     last_r;
  logic                     last_nxt;
  logic                     sclk_r;
  logic                     sclk_nxt;
  logic                     sel_n_r;
  logic                     sel_n_nxt;
  logic                     strobe_n_r;
  logic                     strobe_n_nxt;
  logic                     data_r;
  logic                     data_nxt;
  logic                     oe_r;
  logic                     oe_nxt;

  wire                      wait_done  = (timer_r == TIMER_ONE);
  wire                      take_cmd   = cmd_valid_in && cmd_ready_out;
  wire                      last_bit   = (bit_r == LAST_BIT_CNT);
  // the final bit is a don't care; one is sent so the data line ends each byte high
  wire [CMD_BITS-1:0]       cmd_byte   = cmd_precharge_in ? PRECHARGE_BYTE :
                                         {cmd_value_in, cmd_addr_in, 1'b1};

  assign cmd_ready_out = (state_r == H_IDLE) || (state_r == H_NEXT);
  assign busy_out      = (state_r != H_IDLE);

  always_comb
  begin
    state_nxt    = state_r;
    timer_nxt    = wait_done ? timer_r : timer_r - TIMER_ONE;
    byte_nxt     = byte_r;
    bit_nxt      = bit_r;
    pre_nxt      = pre_r;
    last_nxt     = last_r;
    sclk_nxt     = sclk_r;
    sel_n_nxt    = sel_n_r;
    strobe_n_nxt = strobe_n_r;
    data_nxt     = data_r;
    oe_nxt       = oe_r;
    case (state_r)
      H_IDLE:
      begin
        sclk_nxt = 1'b1;
        if (take_cmd)
        begin
          byte_nxt     = cmd_byte;
          pre_nxt      = cmd_precharge_in;
          last_nxt     = cmd_last_in;
          strobe_n_nxt = 1'b0;
          timer_nxt    = cmd_precharge_in ? PRECHARGE_CYC : SETUP_CYC;
          state_nxt    = H_STROBE;
        end
      end
      H_STROBE:
      begin
        if (wait_done)
        begin
          sel_n_nxt = 1'b0;
          timer_nxt = SETUP_CYC;
          state_nxt = H_SELECT;
        end
      end
      H_SELECT:
      begin
        if (wait_done)
        begin
          sclk_nxt  = 1'b0;
          data_nxt  = byte_r[CMD_BITS-1];
          oe_nxt    = !pre_r;
          byte_nxt  = {byte_r[CMD_BITS-2:0], 1'b0};
          bit_nxt   = 3'h0;
          timer_nxt = SCLK_HALF_CYC;
          state_nxt = H_LOW;
        end
      end
      H_LOW:
      begin
        if (wait_done)
        begin
          sclk_nxt  = 1'b1;
          timer_nxt = SCLK_HALF_CYC;
          state_nxt = H_HIGH;
        end
      end
      H_HIGH:
      begin
        if (wait_done && last_bit && last_r)
        begin
          oe_nxt       = 1'b0;
          strobe_n_nxt = pre_r ? 1'b1 : strobe_n_r;
          timer_nxt    = SETUP_CYC;
          state_nxt    = H_DROP;
        end
        else if (wait_done && last_bit)
        begin
          state_nxt = H_NEXT;
        end
        else if (wait_done)
        begin
          // new value only after the falling edge, steady across the rise
          sclk_nxt  = 1'b0;
          data_nxt  = byte_r[CMD_BITS-1];
          byte_nxt  = {byte_r[CMD_BITS-2:0], 1'b0};
          bit_nxt   = bit_r + 3'h1;
          timer_nxt = SCLK_HALF_CYC;
          state_nxt = H_LOW;
        end
      end
      H_NEXT:
      begin
        // clock parks high between bytes, which only lengthens the period
        if (take_cmd)
        begin
          pre_nxt   = cmd_precharge_in;
          last_nxt  = cmd_last_in;
          sclk_nxt  = 1'b0;
          data_nxt  = cmd_byte[CMD_BITS-1];
          oe_nxt    = !cmd_precharge_in;
          byte_nxt  = {cmd_byte[CMD_BITS-2:0], 1'b0};
          bit_nxt   = 3'h0;
          timer_nxt = SCLK_HALF_CYC;
          state_nxt = H_LOW;
        end
      end
      H_DROP:
      begin
        if (wait_done)
        begin
          sel_n_nxt    = 1'b1;
          strobe_n_nxt = 1'b1;
          timer_nxt    = SETUP_CYC;
          state_nxt    = H_RELEASE;
        end
      end
      H_RELEASE:
      begin
        // idle gap so the next frame starts from all lines high
        if (wait_done)
        begin
          state_nxt = H_IDLE;
        end
      end
      default:
      begin
        state_nxt = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_r    <= H_IDLE;
      timer_r    <= TIMER_ONE;
      byte_r     <= 8'h00;
      bit_r      <= 3'h0;
      pre_r      <= 1'b0;
      last_r     <= 1'b1;
      sclk_r     <= 1'b1;
      sel_n_r    <= 1'b1;
      strobe_n_r <= 1'b1;
      data_r     <= 1'b1;
      oe_r       <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      timer_r    <= timer_nxt;
      byte_r     <= byte_nxt;
      bit_r      <= bit_nxt;
      pre_r      <= pre_nxt;
      last_r     <= last_nxt;
      sclk_r     <= sclk_nxt;
      sel_n_r    <= sel_n_nxt;
      strobe_n_r <= strobe_n_nxt;
      data_r     <= data_nxt;
      oe_r       <= oe_nxt;
    end
  end

  // in reset the link clock follows sys_clk_in so the device sees its power-on
  // reset edges; sclk_r parks high, so release on a high phase makes no false edge
  assign link.sclk           = rst_in ? sys_clk_in : sclk_r;
  assign link.port_select_n  = sel_n_r;
  assign link.latch_strobe_n = strobe_n_r;
  assign link.host_data_out  = data_r;
  assign link.host_data_oe   = oe_r;

endmodule : latch_write_host

/* File: include/latch_port_pkg.sv */
/*
  shared constants, timing counts and state type of the serial latch write port.
  assumes a 100 MHz system clock on the host end; the device end runs on the serial clock.
*/
package latch_port_pkg;

  localparam int SYS_PERIOD_NS     = 10;
  localparam int T_SCLK_PERIOD_NS  = 10000;
  localparam int T_SETUP_NS        = 30;
  localparam int T_PRECHARGE_NS    = 1000;

  localparam int TIMER_W           = 10;
  // half period and setup strictly longer than the printed figures, hence the +1; precharge is rounded up to exactly 1 us
  localparam logic [TIMER_W-1:0] SCLK_HALF_CYC =
    TIMER_W'(T_SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS) + 1);
  localparam logic [TIMER_W-1:0] SETUP_CYC =
    TIMER_W'(T_SETUP_NS / SYS_PERIOD_NS + 1);
  localparam logic [TIMER_W-1:0] PRECHARGE_CYC =
    TIMER_W'((T_PRECHARGE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [TIMER_W-1:0] TIMER_ONE = 10'h001;

  localparam int CMD_BITS          = 8;
  localparam int ADDR_W            = 6;
  localparam int CNT_W             = 3;
  localparam int CMD_DATA_POS      = 6;
  localparam int CFG_BITS          = 56;
  localparam int MODE_BITS         = 6;
  localparam int MODE_IDX_W        = 3;
  localparam logic [CNT_W-1:0]  LAST_BIT_CNT   = 3'h7;
  localparam logic [ADDR_W-1:0] MODE_BASE      = 6'h38;
  localparam logic [ADDR_W-1:0] PRECHARGE_ADDR = 6'h3f;
  localparam logic [CMD_BITS-1:0] PRECHARGE_BYTE = 8'hff;
  localparam logic [CFG_BITS-1:0]  CFG_RESET  = 56'h00_0000_0000_0000;
  localparam logic [MODE_BITS-1:0] MODE_RESET = 6'h00;

  typedef enum {
    H_IDLE,
    H_STROBE,
    H_SELECT,
    H_LOW,
    H_HIGH,
    H_NEXT,
    H_DROP,
    H_RELEASE
  } host_state_t;

endpackage : latch_port_pkg

/* File: include/latch_link_if.sv */
/*
  four-wire link between host and device: select, latch strobe, serial clock, data.
  assumes the testbench instantiates it; the data wire is resolved here with a pull-up.
*/
`timescale 1ns/1ps
interface latch_link_if;
  logic sclk;
  logic port_select_n;
  logic latch_strobe_n;
  logic host_data_out;
  logic host_data_oe;
  logic dev_data_out;
  logic dev_data_oe;
  logic host_data_pin;

  // weak pull-up: an undriven pin reads as one
  assign host_data_pin = host_data_oe ? host_data_out :
                         (dev_data_oe ? dev_data_out : 1'b1);

  modport host (
    output sclk,
    output port_select_n,
    output latch_strobe_n,
    output host_data_out,
    output host_data_oe,
    input  host_data_pin
  );

  modport dev (
    input  sclk,
    input  port_select_n,
    input  latch_strobe_n,
    input  host_data_pin,
    output dev_data_out,
    output dev_data_oe
  );
endinterface : latch_link_if

/* File: core/latch_write_device.sv */
/*
  device end: shifts command bytes on the serial clock and writes the addressed latch.
  assumes the host keeps select and strobe steady around serial clock edges, and that
  power-on reset sees at least two serial clock edges.
*/
`timescale 1ns/1ps
module latch_write_device
  import latch_port_pkg::*;
(
  input  wire logic                 rst_in,
  latch_link_if.dev                 link,
  input  wire logic                 read_bit_in,
  output logic [CFG_BITS-1:0]       cfg_bits_out,
  output logic [MODE_BITS-1:0]      mode_bits_out,
  output logic                      swap_order_out
);

  logic [CNT_W-1:0]         cnt_r;
  logic [CMD_DATA_POS:0]    shift_r;
  logic [CFG_BITS-1:0]      cfg_r;
  logic [CFG_BITS-1:0]      cfg_nxt;
  logic [MODE_BITS-1:0]     mode_r;
  logic [MODE_BITS-1:0]     mode_nxt;
  logic                     swap_r;
  logic                     swap_nxt;

  // select and strobe are qualifiers held steady by the host around each edge
  wire                      write_mode = !link.port_select_n && !link.latch_strobe_n;
  wire                      read_mode  = !link.port_select_n && link.latch_strobe_n;
  wire                      frame_end  = !write_mode;
  wire                      exec       = write_mode && (cnt_r == LAST_BIT_CNT);
  wire                      cmd_data   = shift_r[CMD_DATA_POS];
  wire [ADDR_W-1:0]         cmd_addr   = shift_r[ADDR_W-1:0];
  wire                      hit_cfg    = (32'(cmd_addr) < CFG_BITS);
  wire [ADDR_W-1:0]         mode_off   = cmd_addr - MODE_BASE;
  wire                      hit_mode   = (cmd_addr >= MODE_BASE) &&
                                         (32'(mode_off) < MODE_BITS);
  wire                      hit_pre    = (cmd_addr == PRECHARGE_ADDR);
  wire [MODE_IDX_W-1:0]     mode_idx   = mode_off[MODE_IDX_W-1:0];

  // the frame has no clock edge after its end, so leaving write mode clears the count
  always_ff @(posedge link.sclk or posedge frame_end)
  begin
    if (frame_end)
    begin
      cnt_r   <= 3'h0;
      shift_r <= 7'h00;
    end
    else if (rst_in)
    begin
      cnt_r   <= 3'h0;
      shift_r <= 7'h00;
    end
    else
    begin
      cnt_r   <= cnt_r + 3'h1;
      shift_r <= {shift_r[CMD_DATA_POS-1:0], link.host_data_pin};
    end
  end

  // the last bit's value is never used; its edge alone performs the write
  always_comb
  begin
    cfg_nxt  = cfg_r;
    mode_nxt = mode_r;
    if (exec && hit_cfg)
    begin
      cfg_nxt[cmd_addr] = cmd_data;
    end
    if (exec && hit_mode)
    begin
      mode_nxt[mode_idx] = cmd_data;
    end
  end

  // precharge is not kept as a latch; it only flips the order of the next read
  assign swap_nxt = (exec && hit_pre) ? 1'b1 :
                    (read_mode ? 1'b0 : swap_r);

  // only power-on reset touches the port state
  always_ff @(posedge link.sclk)
  begin
    if (rst_in)
    begin
      cfg_r  <= CFG_RESET;
      mode_r <= MODE_RESET;
      swap_r <= 1'b0;
    end
    else
    begin
      cfg_r  <= cfg_nxt;
      mode_r <= mode_nxt;
      swap_r <= swap_nxt;
    end
  end

  assign link.dev_data_oe  = read_mode;
  assign link.dev_data_out = read_bit_in;
  assign cfg_bits_out      = cfg_r;
  assign mode_bits_out     = mode_r;
  assign swap_order_out    = swap_r;

endmodule : latch_write_device

/* File: verif/latch_port_chk.sv */
/*
  concurrent checks on the four-wire link between the host and device ends.
  assumes it is instantiated beside the link interface and sampled on the host clock.
*/
`timescale 1ns/1ps
module latch_port_chk
  import latch_port_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic sclk,
  input  wire logic port_select_n,
  input  wire logic latch_strobe_n,
  input  wire logic host_data_out,
  input  wire logic host_data_oe,
  input  wire logic dev_data_oe,
  input  wire logic host_data_pin
);
  logic [15:0] hold_r;
  logic [7:0]  rise_r;
  logic        sclk_r;
  wire         sclk_edge = (sclk != sclk_r);
  wire         sclk_up   = sclk && !sclk_r;
  wire  [15:0] half_min  = 16'(SCLK_HALF_CYC) - 16'h0003;

  // phase length of the serial clock; sampled clock is several sys cycles per phase
  always_ff @(posedge sys_clk_in)
  begin
    sclk_r <= sclk;
    hold_r <= (rst_in || sclk_edge) ? 16'h0000 : hold_r + 16'h0001;
    rise_r <= (rst_in || port_select_n) ? 8'h00 : rise_r + {7'h00, sclk_up};
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_write_mode;
    !port_select_n && !latch_strobe_n;
  endsequence

  a_strobe_lead: assert property (
    $fell(port_select_n) |-> !latch_strobe_n && $past(!latch_strobe_n, 3))
    else $error("select fell without strobe low long enough");
  a_first_bit_setup: assert property (
    $rose(host_data_oe) |-> $past(!port_select_n, 3) ##0 s_write_mode)
    else $error("first bit driven too soon or outside write mode");
  a_data_after_fall: assert property (
    host_data_oe && $past(host_data_oe) && $changed(host_data_out) |-> $fell(sclk))
    else $error("data changed away from a falling serial clock");
  a_sclk_idle_high: assert property (
    !$past(rst_in) && port_select_n |-> sclk)
    else $error("serial clock low while deselected");
  a_half_period_long: assert property (
    !port_select_n && (sclk_up || ($fell(sclk) && $past(host_data_oe))) |-> hold_r >= half_min)
    else $error("serial clock phase too short");
  a_eight_per_byte: assert property (
    $rose(port_select_n) |-> rise_r != 8'h00 && rise_r[2:0] == 3'h0)
    else $error("frame closed on a partial byte");
  a_no_bus_fight: assert property (
    dev_data_oe |-> !host_data_oe)
    else $error("both ends drive the data pin");
  a_release_data: assert property (
    $rose(latch_strobe_n) |-> !host_data_oe && $past(!host_data_oe))
    else $error("strobe released while host still drives data");
  a_driver_decode: assert property (
    dev_data_oe == (!port_select_n && latch_strobe_n))
    else $error("device driver enable does not follow select and strobe");
  a_pullup_ones: assert property (
    !port_select_n && !latch_strobe_n && !host_data_oe |-> host_data_pin)
    else $error("undriven data pin not high in write mode");
endmodule : latch_port_chk

/* File: verif/serial_latch_write_port_bench.sv */
/*
  self-checking bench: host and device ends joined by the link interface.
  assumes the host divides sys_clk_in to make the serial clock; no read traffic.
*/
`timescale 1ns/1ps
module serial_latch_write_port_bench;
  import latch_port_pkg::*;
  logic                 sys_clk_in;
  logic                 rst_in;
  logic                 cmd_valid;
  logic                 cmd_value;
  logic [ADDR_W-1:0]    cmd_addr;
  logic                 cmd_pre;
  logic                 cmd_last;
  logic                 cmd_ready;
  logic                 busy;
  logic                 read_bit;
  logic [CFG_BITS-1:0]  cfg_bits;
  logic [MODE_BITS-1:0] mode_bits;
  logic                 swap_order;
  logic [7:0]           cap_r;
  logic [CFG_BITS-1:0]  exp_cfg;
  logic [MODE_BITS-1:0] exp_mode;
  logic                 exp_swap;
  int                   n_fail;
  int                   cmp_count;

  latch_link_if lk ();

  latch_write_host latch_write_host_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
    .cmd_value_in(cmd_value), .cmd_addr_in(cmd_addr), .cmd_precharge_in(cmd_pre),
    .cmd_last_in(cmd_last), .cmd_ready_out(cmd_ready), .busy_out(busy), .link(lk));
  latch_write_device latch_write_device_i (
    .rst_in(rst_in), .link(lk), .read_bit_in(read_bit), .cfg_bits_out(cfg_bits),
    .mode_bits_out(mode_bits), .swap_order_out(swap_order));
  latch_port_chk latch_port_chk_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .sclk(lk.sclk),
    .port_select_n(lk.port_select_n), .latch_strobe_n(lk.latch_strobe_n),
    .host_data_out(lk.host_data_out), .host_data_oe(lk.host_data_oe),
    .dev_data_oe(lk.dev_data_oe), .host_data_pin(lk.host_data_pin));

  always #5 sys_clk_in = ~sys_clk_in;

  // what the device shifts in, seen from the wire itself
  always @(posedge lk.sclk)
  begin
    if (!lk.port_select_n && !lk.latch_strobe_n)
    begin
      cap_r <= {cap_r[6:0], lk.host_data_pin};
    end
  end

  task check(input logic [CFG_BITS-1:0] got, input logic [CFG_BITS-1:0] exp,
             input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task tick;
    @(posedge sys_clk_in);
    #1;
  endtask : tick

  // a byte lasts about 8000 cycles, so the bound is generous but finite
  task wait_for(input logic want_idle);
    for (int i = 0; i < 20000; i++)
    begin
      tick();
      if (want_idle ? (busy === 1'b0) : (cmd_ready === 1'b1))
      begin
        return;
      end
    end
    n_fail++;
    $display("unexpected at %0t: handshake never came", $time);
    give_verdict();
  endtask : wait_for

  task send(input logic v, input logic [ADDR_W-1:0] a, input logic pre, input logic last);
    logic [7:0] exp_byte;
    exp_byte = pre ? PRECHARGE_BYTE : {v, a, 1'b1};
    if (cmd_ready !== 1'b1)
    begin
      wait_for(1'b0);
    end
    cmd_valid = 1'b1;
    cmd_value = v;
    cmd_addr  = a;
    cmd_pre   = pre;
    cmd_last  = last;
    tick();
    cmd_valid = 1'b0;
    wait_for(last);
    if (pre)
      exp_swap = 1'b1;
    else if (a < CFG_BITS)
      exp_cfg[a] = v;
    else if (a >= MODE_BASE && a < MODE_BASE + MODE_BITS)
      exp_mode[a - MODE_BASE] = v;
    check(cap_r, exp_byte, "wire byte");
    check(cfg_bits, exp_cfg, "config latches");
    check(mode_bits, exp_mode, "mode latches");
    check(swap_order, exp_swap, "swap flag");
  endtask : send

  initial
  begin
    sys_clk_in = 1'b0;
    rst_in     = 1'b1;
    cmd_valid  = 1'b0;
    cmd_value  = 1'b0;
    cmd_addr   = 6'h00;
    cmd_pre    = 1'b0;
    cmd_last   = 1'b0;
    read_bit   = 1'b0;
    exp_cfg    = CFG_RESET;
    exp_mode   = MODE_RESET;
    exp_swap   = 1'b0;
    n_fail     = 0;
    cmp_count  = 0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    rst_in = 1'b0;
    tick();
    check(cfg_bits, CFG_RESET, "config after reset");
    check(mode_bits, MODE_RESET, "mode after reset");
    check(swap_order, 1'b0, "swap after reset");
    send(1'b1, 6'h2f, 1'b0, 1'b1);
    // one frame of three bytes, touching both ends of the mode range and the top of the config range
    send(1'b1, MODE_BASE, 1'b0, 1'b0);
    send(1'b1, 6'h37, 1'b0, 1'b0);
    send(1'b1, 6'h3d, 1'b0, 1'b1);
    send(1'b1, 6'h3e, 1'b0, 1'b1);
    send(1'b0, 6'h2f, 1'b0, 1'b1);
    send(1'b0, 6'h00, 1'b1, 1'b1);
    give_verdict();
  end
endmodule : serial_latch_write_port_bench
